// file: rtl/cabce_regs.vh
// constants for the add/and/bit/call execute block: bus offsets, field positions,
// opcodes, reset values and t-state counts.
// assumes byte addresses on an avalon-mm slave with 32-bit data.
`ifndef CABCE_REGS_VH
`define CABCE_REGS_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CABCE_OFS_INSTR 11'h000
`define CABCE_OFS_STATUS 11'h004
`define CABCE_OFS_PC 11'h008
`define CABCE_OFS_MODE 11'h00C
`define CABCE_OFS_STKTOP 11'h010
`define CABCE_OFS_IPTR0 11'h020
`define CABCE_REGWIN_TAG 4'h1
`define CABCE_PTRWIN_TAG 7'h02
`define CABCE_OFS_REG0 11'h080
`define CABCE_OFS_DMEM 11'h400
// ----------------------------------------
// mode register fields and reset values
// ----------------------------------------
`define CABCE_MODE_BANKA 0
`define CABCE_MODE_BANKB 1
`define CABCE_MODE_GIE 2
`define CABCE_RST_PC 16'h0000
`define CABCE_RST_BYTE 8'h00
// ----------------------------------------
// opcodes
// ----------------------------------------
`define CABCE_OP_ADDI 4'h0
`define CABCE_OP_ANDI 4'h4
`define CABCE_OP_BIT 4'h5
`define CABCE_OP_ADD_WITH_ACCUMULATOR_RR 6'h38
`define CABCE_OP_AND_WITH_ACCUMULATOR_RR 6'h3C
`define CABCE_OP_ADD_WITH_ACCUMULATOR_IX 7'h50
`define CABCE_OP_AND_WITH_ACCUMULATOR_IX 7'h5A
`define CABCE_OP_CALL 8'h9C
// ----------------------------------------
// index address modes
// ----------------------------------------
`define CABCE_AM_POSTDEC 2'h0
`define CABCE_AM_NOCHG 2'h1
`define CABCE_AM_POSTINC 2'h2
`define CABCE_AM_PREINC 2'h3
// ----------------------------------------
// mapped registers and timing
// ----------------------------------------
`define CABCE_R_NCF 5'h01
`define CABCE_R_ICR 5'h02
`define CABCE_R_ACC 5'h04
`define CABCE_R_TSR 5'h0C
`define CABCE_R_RTR 5'h0D
`define CABCE_RX_DEPTH 2'h3
`define CABCE_TST_SHORT 2'h2
`define CABCE_TST_LONG 2'h3
`endif

// file: rtl/cabce_alu.v
// eight-bit adder / and unit with n, z, c, v flag outputs.
// purely combinational; the caller decides which flags it keeps.
`default_nettype none

module cabce_alu (
  // operands
  input wire [7:0] opA,
  input wire [7:0] opB,
  input wire opAdd,
  // result and flags
  output reg [7:0] res,
  output reg flagN,
  output reg flagZ,
  output reg flagC,
  output reg flagV
);

  reg [8:0] sum9;

  // overflow is the signed view: equal operand signs giving a differing result sign
  always @* begin
    sum9 = {1'b0, opA} + {1'b0, opB};
    if (opAdd) begin
      res = sum9[7:0];
      flagC = sum9[8];
      flagV = (opA[7] == opB[7]) && (sum9[7] != opA[7]);
    end else begin
      res = opA & opB;
      flagC = 1'b0;
      flagV = 1'b0;
    end
    flagN = res[7];
    flagZ = (res == 8'h00);
  end

endmodule // cabce_alu

`default_nettype wire

// file: rtl/cabce_dmem.v
// byte-wide data memory, 256 locations, one write port and one read port.
// read is asynchronous so the bus slave can latch the byte in its answer cycle.
`default_nettype none

module cabce_dmem (
  // clock
  input wire core_clk,
  // write port
  input wire wrEn,
  input wire [7:0] wrAddr,
  input wire [7:0] wrData,
  // read port
  input wire [7:0] rdAddr,
  output wire [7:0] rdData
);

  reg [7:0] mem [0:255];

  // no reset: contents are undefined until written
  always @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  assign rdData = mem[rdAddr];

endmodule // cabce_dmem

`default_nettype wire

// file: rtl/cabce_core.v
// execute unit for add immediate, add/and with accumulator, and immediate, bit test
// and relative call, with banked register file, index pointers, address stack,
// receive fifo window and an avalon-mm slave for software.
// assumes rxPush/rxWord come from logic on core_clk; txEmptyPin is asynchronous.
//
// How it works
// - add immediate sums byte into limited register, writes back, sets n z c v
// - add immediate reaches only r0 to r15; immediate is eight bits
// - add with accumulator: source plus accumulator to register or indexed memory, n z c v
// - accumulator follows bank b selection, main or alternate
// - register form of add with accumulator: 111000, destination, source fields
// - indexed form: 1010000, mode, pointer select, source in bits 4..0
// - mode codes post-dec, none, post-inc, pre-inc; select picks one of four pointers
// - register forms take two t-states, indexed forms take three
// - and immediate on r0..r15, writes back, touches only n and z
// - and immediate opcode 0100 above immediate and limited register
// - and with accumulator to register or indexed memory, only n and z
// - bit test ands limited register with immediate, flags only, no write
// - call pushes pc, flags, interrupt enable and bank selections together
// - call target is pc plus sign-extended eight-bit displacement
// - pc used for the target already points past the call
// - receive fifo holds three 11-bit words; status shows top bits, data read pops
// - interrupt control is register 2; clearing low bits unmasks tx and rx only
// - transmit-empty flag lives in register 1 for polling by bit test
// - call is 8-bit opcode over 8-bit displacement, three t-states
//
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`default_nettype none
`include "cabce_regs.vh"
module cabce_core (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // avalon-mm slave
  input wire [10:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // transceiver side
  input wire txEmptyPin,
  input wire rxPush,
  input wire [10:0] rxWord,
  output reg [7:0] irqMask
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_EXEC = 2'b10;
  reg [1:0] st_r;
  reg [1:0] tcnt_r;
  reg [15:0] ir_r;
  reg [15:0] pc_r;
  reg [3:0] flags_r;
  reg gie_r;
  reg bankA_r;
  reg bankB_r;
  reg illegal_r;
  reg [7:0] rf [0:43];
  reg [7:0] ncf_r;
  reg [15:0] iptr [0:3];
  reg [22:0] stk [0:3];
  reg [1:0] sp_r;
  reg [10:0] rxq [0:2];
  reg [1:0] rxCnt_r;
  reg rxOvf_r;
  reg txS1_r;
  reg txS2_r;
  reg txS3_r;
  reg txEmpty_r;
  integer i;
  // ----------------------------------------
  // register view helpers
  // ----------------------------------------
  // alternates exist for r0..r3 (bank a) and r4..r11 (bank b); alternate copy sits at 32+n
  function [5:0] physIdx;
    input [4:0] n;
    input ba;
    input bb;
    begin
      if ((n < 5'h04 && ba) || (n >= 5'h04 && n < 5'h0C && bb)) begin
        physIdx = {1'b1, n};
      end else begin
        physIdx = {1'b0, n};
      end
    end
  endfunction
  // one wire per register number, so every reader follows the state it shows; mapped ones overlay
  wire [7:0] regView [0:31];
  genvar gv;
  generate
    for (gv = 0; gv < 32; gv = gv + 1) begin : gRegView
      localparam [4:0] RN = gv;
      assign regView[gv] = (RN == `CABCE_R_NCF) ? {ncf_r[7:1], txEmpty_r} :
                           (RN == `CABCE_R_ICR) ? irqMask :
                           (RN == `CABCE_R_TSR) ? {5'h00, rxq[0][10:8]} :
                           (RN == `CABCE_R_RTR) ? rxq[0][7:0] :
                           rf[physIdx(RN, bankA_r, bankB_r)];
    end
  endgenerate
  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire isAddI = (ir_r[15:12] == `CABCE_OP_ADDI);
  wire isAndI = (ir_r[15:12] == `CABCE_OP_ANDI);
  wire isBit = (ir_r[15:12] == `CABCE_OP_BIT);
  wire isAddaR = (ir_r[15:10] == `CABCE_OP_ADD_WITH_ACCUMULATOR_RR);
  wire isAndaR = (ir_r[15:10] == `CABCE_OP_AND_WITH_ACCUMULATOR_RR);
  wire isAddaX = (ir_r[15:9] == `CABCE_OP_ADD_WITH_ACCUMULATOR_IX);
  wire isAndaX = (ir_r[15:9] == `CABCE_OP_AND_WITH_ACCUMULATOR_IX);
  wire isCall = (ir_r[15:8] == `CABCE_OP_CALL);
  wire immForm = isAddI | isAndI | isBit;
  wire accReg = isAddaR | isAndaR;
  wire accIdx = isAddaX | isAndaX;
  wire known = immForm | accReg | accIdx | isCall;
  wire [1:0] tNeed = (accIdx | isCall) ? `CABCE_TST_LONG : `CABCE_TST_SHORT;
  wire [4:0] srcIdx = immForm ? {1'b0, ir_r[3:0]} : ir_r[4:0];
  wire [1:0] amode = ir_r[8:7];
  wire [1:0] ptrSel = ir_r[6:5];
  wire commit = st_r[1] && (tcnt_r == tNeed - 2'h1);
  // ----------------------------------------
  // alu
  // ----------------------------------------
  wire [7:0] aluA = regView[srcIdx];
  wire [7:0] aluB = immForm ? ir_r[11:4] : regView[`CABCE_R_ACC];
  wire aluAdd = isAddI | isAddaR | isAddaX;
  wire [7:0] aluRes;
  wire aluN;
  wire aluZ;
  wire aluC;
  wire aluV;
  cabce_alu cabce_alu_inst (
    .opA(aluA),
    .opB(aluB),
    .opAdd(aluAdd),
    .res(aluRes),
    .flagN(aluN),
    .flagZ(aluZ),
    .flagC(aluC),
    .flagV(aluV)
  );
  // ----------------------------------------
  // indexed addressing and call target
  // ----------------------------------------
  wire [15:0] ptrNow = iptr[ptrSel];
  wire [15:0] ptrInc = ptrNow + 16'h0001;
  wire [15:0] ptrDec = ptrNow - 16'h0001;
  wire [15:0] memAddr = (amode == `CABCE_AM_PREINC) ? ptrInc : ptrNow;
  wire [15:0] pcNext = pc_r + 16'h0001;
  wire [15:0] callTgt = pcNext + {{8{ir_r[7]}}, ir_r[7:0]};
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire busDone = !avs_waitrequest;
  wire busWr = busDone && avs_write;
  wire busRd = busDone && avs_read;
  wire inRegWin = (avs_address[10:7] == `CABCE_REGWIN_TAG);
  wire inMemWin = avs_address[10];
  wire [4:0] busReg = avs_address[6:2];
  wire inPtrWin = (avs_address[10:4] == `CABCE_PTRWIN_TAG);
  wire [1:0] busPtr = avs_address[3:2];
  wire [7:0] memRd;
  // register file write port: instruction result or software
  wire instrWr = commit && (isAddI | isAndI | accReg);
  wire busRegWr = busWr && inRegWin;
  wire regWr = instrWr | busRegWr;
  wire [4:0] wrIdx = instrWr ? (accReg ? ir_r[9:5] : {1'b0, ir_r[3:0]}) : busReg;
  wire [7:0] wrVal = instrWr ? aluRes : avs_writedata[7:0];
  wire memInstrWr = commit && accIdx;
  wire popRx = (commit && (immForm | accReg | accIdx) && srcIdx == `CABCE_R_RTR) ||
               (busRd && inRegWin && busReg == `CABCE_R_RTR);
  cabce_dmem cabce_dmem_inst (
    .core_clk(core_clk),
    .wrEn(memInstrWr | (busWr && inMemWin)),
    .wrAddr(memInstrWr ? memAddr[7:0] : avs_address[9:2]),
    .wrData(memInstrWr ? aluRes : avs_writedata[7:0]),
    .rdAddr(avs_address[9:2]),
    .rdData(memRd)
  );
  // read mux, sampled in the cycle waitrequest drops
  reg [31:0] rdMux;
  always @* begin
    rdMux = 32'h0000_0000;
    if (inMemWin) begin
      rdMux = {24'h00_0000, memRd};
    end else if (inRegWin) begin
      rdMux = {24'h00_0000, regView[busReg]};
    end else if (inPtrWin) begin
      rdMux = {16'h0000, iptr[busPtr]};
    end else begin
      case (avs_address)
        `CABCE_OFS_INSTR: rdMux = {16'h0000, ir_r};
        `CABCE_OFS_STATUS: rdMux = {21'h0, illegal_r, rxOvf_r, sp_r, bankB_r, bankA_r, gie_r, flags_r};
        `CABCE_OFS_PC: rdMux = {16'h0000, pc_r};
        `CABCE_OFS_MODE: rdMux = {29'h0, gie_r, bankB_r, bankA_r};
        `CABCE_OFS_STKTOP: rdMux = {9'h000, stk[sp_r - 2'h1]};
        default: rdMux = 32'h0000_0000;
      endcase
    end
  end
  // ----------------------------------------
  // bus slave handshake
  // ----------------------------------------
  // every access waits while an instruction runs, so software never races the datapath
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && st_r[0]) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? rdMux : 32'h0000_0000;
    end
  end
  // ----------------------------------------
  // sequencer, pc, flags, stack
  // ----------------------------------------
  // t-states are counted in EXEC; the last one commits all results at once
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_IDLE;
      tcnt_r <= 2'h0;
      ir_r <= 16'h0000;
      pc_r <= `CABCE_RST_PC;
      flags_r <= 4'h0;
      gie_r <= 1'b0;
      bankA_r <= 1'b0;
      bankB_r <= 1'b0;
      illegal_r <= 1'b0;
      sp_r <= 2'h0;
      for (i = 0; i < 4; i = i + 1) begin
        stk[i] <= 23'h00_0000;
      end
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (busWr && avs_address == `CABCE_OFS_INSTR) begin
            ir_r <= avs_writedata[15:0];
            tcnt_r <= 2'h0;
            st_r <= ST_EXEC;
          end else if (busWr && avs_address == `CABCE_OFS_PC) begin
            pc_r <= avs_writedata[15:0];
          end else if (busWr && avs_address == `CABCE_OFS_MODE) begin
            bankA_r <= avs_writedata[`CABCE_MODE_BANKA];
            bankB_r <= avs_writedata[`CABCE_MODE_BANKB];
            gie_r <= avs_writedata[`CABCE_MODE_GIE];
          end
        end
        ST_EXEC: begin
          tcnt_r <= tcnt_r + 2'h1;
          if (commit) begin
            st_r <= ST_IDLE;
            illegal_r <= !known;
            pc_r <= isCall ? callTgt : pcNext;
            if (isCall) begin
              stk[sp_r] <= {pcNext, gie_r, flags_r, bankA_r, bankB_r};
              sp_r <= sp_r + 2'h1;
            end
            if (isAddI || isAddaR || isAddaX) begin
              flags_r <= {aluN, aluZ, aluC, aluV};
            end else if (isAndI || isBit || isAndaR || isAndaX) begin
              flags_r <= {aluN, aluZ, flags_r[1:0]};
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // register file and mapped registers
  // ----------------------------------------
  // r12/r13 are fifo views and ignore writes; bit test never reaches here
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ncf_r <= `CABCE_RST_BYTE;
      irqMask <= 8'hFF;
      for (i = 0; i < 44; i = i + 1) begin
        rf[i] <= `CABCE_RST_BYTE;
      end
    end else if (regWr) begin
      case (wrIdx)
        `CABCE_R_NCF: ncf_r <= wrVal;
        `CABCE_R_ICR: irqMask <= wrVal;
        `CABCE_R_TSR, `CABCE_R_RTR: ncf_r <= ncf_r;
        default: rf[physIdx(wrIdx, bankA_r, bankB_r)] <= wrVal;
      endcase
    end
  end
  // ----------------------------------------
  // index pointers
  // ----------------------------------------
  // pre-increment addresses with ptr+1; post modes address with the old value
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        iptr[i] <= 16'h0000;
      end
    end else if (memInstrWr) begin
      case (amode)
        `CABCE_AM_POSTDEC: iptr[ptrSel] <= ptrDec;
        `CABCE_AM_NOCHG: iptr[ptrSel] <= ptrNow;
        `CABCE_AM_POSTINC: iptr[ptrSel] <= ptrInc;
        `CABCE_AM_PREINC: iptr[ptrSel] <= ptrInc;
        default: iptr[ptrSel] <= ptrNow;
      endcase
    end else if (busWr && inPtrWin) begin
      iptr[busPtr] <= avs_writedata[15:0];
    end
  end
  // ----------------------------------------
  // receive fifo, three words of 11 bits
  // ----------------------------------------
  // a push into a full fifo with no pop in the same cycle is dropped and sticks the overflow bit
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxCnt_r <= 2'h0;
      rxOvf_r <= 1'b0;
      for (i = 0; i < 3; i = i + 1) begin
        rxq[i] <= 11'h000;
      end
    end else begin
      if (popRx && rxCnt_r != 2'h0) begin
        rxq[0] <= rxq[1];
        rxq[1] <= rxq[2];
        if (rxPush) begin
          rxq[rxCnt_r - 2'h1] <= rxWord;
        end else begin
          rxCnt_r <= rxCnt_r - 2'h1;
        end
      end else if (rxPush) begin
        if (rxCnt_r == `CABCE_RX_DEPTH) begin
          rxOvf_r <= 1'b1;
        end else begin
          rxq[rxCnt_r] <= rxWord;
          rxCnt_r <= rxCnt_r + 2'h1;
        end
      end
      if (busWr && avs_address == `CABCE_OFS_STATUS && avs_writedata[9] && !(rxPush && rxCnt_r == `CABCE_RX_DEPTH)) begin
        rxOvf_r <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // transmit-empty pin synchroniser
  // ----------------------------------------
  // three stages; the level moves only when stages two and three agree
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txS1_r <= 1'b0;
      txS2_r <= 1'b0;
      txS3_r <= 1'b0;
      txEmpty_r <= 1'b0;
    end else begin
      txS1_r <= txEmptyPin;
      txS2_r <= txS1_r;
      txS3_r <= txS2_r;
      if (txS2_r == txS3_r) begin
        txEmpty_r <= txS3_r;
      end
    end
  end
endmodule // cabce_core
`default_nettype wire

// file: testbench/cabce_core_checker.sv
// checker for the execute block: bus handshake and interrupt mask timing.
// assumes one core_clk domain; rst is asynchronous and active high.
`default_nettype none

module cabce_core_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register bus
  input wire logic [10:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // transceiver side
  input wire logic txEmptyPin,
  input wire logic rxPush,
  input wire logic [10:0] rxWord,
  input wire logic [7:0] irqMask
);
  timeunit 1ns;
  timeprecision 100ps;
  logic wrDone;
  logic instrDone;
  logic andMask;
  logic [7:0] expMask_r;
  logic [3:0] sinceWr_r;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  // accepted writes, and an and-immediate aimed at the mask register
  assign wrDone = avs_write && !avs_waitrequest;
  assign instrDone = wrDone && (avs_address == 11'h000);
  assign andMask = instrDone && (avs_writedata[15:12] == 4'h4) && (avs_writedata[3:0] == 4'h2);
  // expected mask and age of the last write; age saturates so it never wraps back to small
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      expMask_r <= 8'hFF;
      sinceWr_r <= 4'hF;
    end else begin
      if (andMask)
        expMask_r <= irqMask & avs_writedata[11:4];
      if (wrDone)
        sinceWr_r <= 4'h0;
      else if (sinceWr_r != 4'hF)
        sinceWr_r <= sinceWr_r + 4'h1;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  wait_one_cycle_a:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low longer than one cycle");
  wait_cause_a:
    assert property (!avs_waitrequest |-> $past(avs_read || avs_write)) else $error("answer without request");
  answer_bound_a:
    assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:8] !avs_waitrequest)
      else $error("request not answered in time");
  write_zero_a:
    assert property (wrDone |-> avs_readdata == 32'h0000_0000) else $error("readdata not zero on write");
  unmapped_zero_a:
    assert property (avs_read && !avs_waitrequest && avs_address == 11'h200 |-> avs_readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
  busy_hold_a:
    assert property (instrDone |=> avs_waitrequest [*2]) else $error("bus served while instruction runs");
  and_mask_a:
    assert property (andMask |-> ##[1:3] irqMask == expMask_r) else $error("mask not anded");
  mask_write_a:
    assert property (wrDone && avs_address == 11'h088 |=> irqMask == $past(avs_writedata[7:0]))
      else $error("mask not written");
  mask_cause_a:
    assert property ($changed(irqMask) |-> sinceWr_r <= 4'h3) else $error("mask changed without write");
endmodule // cabce_core_checker

bind cabce_core cabce_core_checker cabce_core_checker_inst (.core_clk(core_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .txEmptyPin(txEmptyPin),
  .rxPush(rxPush), .rxWord(rxWord), .irqMask(irqMask));
`default_nettype wire

// file: testbench/cabce_tb.sv
// self-checking bench for the execute block, driven over its avalon-mm slave.
// assumes the register header is on the include path; the checker binds itself.
`default_nettype none
`include "cabce_regs.vh"

module cabce_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [10:0] RXW [3] = '{11'h5A1, 11'h2B2, 11'h7C3};
  logic coreClk = 1'b0;
  logic rst = 1'b1;
  logic [10:0] avsAddress = 11'h000;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0000_0000;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic txEmptyPin = 1'b0;
  logic rxPush = 1'b0;
  logic [10:0] rxWord = 11'h000;
  logic [7:0] irqMask;
  logic [31:0] q;
  int errTotal = 0;
  int checksDone = 0;
  int lastWait = 0;
  int execWait = 0;
  int waitShort = 0;

  cabce_core cabce_core_inst (.core_clk(coreClk), .rst(rst), .avs_address(avsAddress), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest), .txEmptyPin(txEmptyPin), .rxPush(rxPush), .rxWord(rxWord),
    .irqMask(irqMask));

  // 25 MHz core clock
  always #20 coreClk = ~coreClk;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic completeRun;
    $display("checks %0d, errors %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // one bus access; held until waitrequest is sampled low at a rising edge, released right after it
  task automatic xfer(input logic [10:0] a, input logic isWr, input logic [31:0] d);
    int n;
    n = 0;
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= isWr;
    avsRead <= ~isWr;
    do begin
      @(posedge coreClk);
      n++;
    end while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    lastWait = n;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge coreClk);
  endtask

  task automatic rdChk(input string what, input logic [10:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(what, e, q & m);
  endtask

  function automatic logic [10:0] regA(input int n);
    return `CABCE_OFS_REG0 + 11'(n * 4);
  endfunction

  // start an instruction, then time how long the next access is held off; q ends as the pc
  task automatic exec(input logic [15:0] ins);
    xfer(`CABCE_OFS_INSTR, 1'b1, {16'h0000, ins});
    xfer(`CABCE_OFS_PC, 1'b0, 32'h0000_0000);
    execWait = lastWait;
  endtask

  task automatic immCase(input logic [3:0] op, input int rg, input logic [7:0] init, input logic [7:0] imm,
      input logic [7:0] res, input logic [3:0] flg);
    xfer(regA(rg), 1'b1, {24'h0, init});
    exec({op, imm, 4'(rg)});
    rdChk("register", regA(rg), 32'h0000_00FF, {24'h0, res});
    rdChk("flags", `CABCE_OFS_STATUS, 32'h0000_000F, {28'h0, flg});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic tReset;
    chk("mask at reset", 32'h0000_00FF, {24'h0, irqMask});
    rdChk("status at reset", `CABCE_OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
    xfer(11'h200, 1'b1, 32'h0000_00AA);
    rdChk("unmapped", 11'h200, 32'hFFFF_FFFF, 32'h0000_0000);
  endtask

  // immediate forms: overflow, carry to zero, flags kept by and/bit, mask and tx-empty polling
  task automatic tImm;
    immCase(`CABCE_OP_ADDI, 10, 8'h7F, 8'h01, 8'h80, 4'b1001);
    waitShort = execWait;
    immCase(`CABCE_OP_ADDI, 3, 8'hFD, 8'h03, 8'h00, 4'b0110);
    immCase(`CABCE_OP_ADDI, 15, 8'h80, 8'h80, 8'h00, 4'b0111);
    immCase(`CABCE_OP_ANDI, 5, 8'h93, 8'hF0, 8'h90, 4'b1011);
    immCase(`CABCE_OP_BIT, 5, 8'h90, 8'h0F, 8'h90, 4'b0111);
    immCase(`CABCE_OP_ANDI, 2, 8'hFF, 8'hFC, 8'hFC, 4'b1011);
    chk("mask", 32'h0000_00FC, {24'h0, irqMask});
    txEmptyPin <= 1'b1;
    repeat (6) @(posedge coreClk);
    immCase(`CABCE_OP_BIT, 1, 8'h00, 8'h01, 8'h01, 4'b0011);
    txEmptyPin <= 1'b0;
    repeat (6) @(posedge coreClk);
    immCase(`CABCE_OP_BIT, 1, 8'h00, 8'h01, 8'h00, 4'b0111);
  endtask

  // register forms against the alternate then the main accumulator
  task automatic tAcc;
    xfer(regA(4), 1'b1, 32'h0000_0011);
    xfer(regA(20), 1'b1, 32'h0000_00F5);
    xfer(`CABCE_OFS_MODE, 1'b1, 32'h0000_0002);
    xfer(regA(4), 1'b1, 32'h0000_0022);
    exec({6'b111000, 5'd21, 5'd20});
    chk("short latency", 32'(waitShort), 32'(execWait));
    rdChk("alt sum", regA(21), 32'h0000_00FF, 32'h0000_0017);
    xfer(`CABCE_OFS_MODE, 1'b1, 32'h0000_0000);
    exec({6'b111000, 5'd21, 5'd20});
    rdChk("main sum", regA(21), 32'h0000_00FF, 32'h0000_0006);
    rdChk("sum flags", `CABCE_OFS_STATUS, 32'h0000_000F, 32'h0000_0002);
    exec({6'b111100, 5'd22, 5'd20});
    rdChk("and result", regA(22), 32'h0000_00FF, 32'h0000_0011);
    rdChk("and flags", `CABCE_OFS_STATUS, 32'h0000_000F, 32'h0000_0002);
  endtask

  // every address mode, each on its own pointer
  task automatic tIndex;
    logic [15:0] p;
    logic [15:0] a;
    logic [15:0] np;
    for (int m = 0; m < 4; m++) begin
      p = 16'h0020 + 16'(m) * 16'h0010;
      a = (m == 3) ? p + 16'h0001 : p;
      np = (m == 0) ? p - 16'h0001 : (m == 1) ? p : p + 16'h0001;
      xfer(`CABCE_OFS_IPTR0 + 11'(m * 4), 1'b1, {16'h0000, p});
      exec({7'h50, 2'(m), 2'(m), 5'd20});
      chk("long latency", 32'(waitShort + 1), 32'(execWait));
      rdChk("indexed store", `CABCE_OFS_DMEM + {1'b0, a[7:0], 2'b00}, 32'h0000_00FF, 32'h0000_0006);
      rdChk("pointer", `CABCE_OFS_IPTR0 + 11'(m * 4), 32'h0000_FFFF, {16'h0000, np});
    end
    exec({7'h5A, 2'b01, 2'b01, 5'd20});
    rdChk("indexed and", `CABCE_OFS_DMEM + 11'h0C0, 32'h0000_00FF, 32'h0000_0011);
  endtask

  // fill past full, then read status/data pairs in order
  task automatic tRx;
    for (int i = 0; i < 3; i++) begin
      rxWord <= RXW[i];
      rxPush <= 1'b1;
      @(posedge coreClk);
      rxPush <= 1'b0;
      @(posedge coreClk);
    end
    rxWord <= 11'h111;
    rxPush <= 1'b1;
    @(posedge coreClk);
    rxPush <= 1'b0;
    @(posedge coreClk);
    rdChk("rx overflow", `CABCE_OFS_STATUS, 32'h0000_0200, 32'h0000_0200);
    for (int i = 0; i < 3; i++) begin
      rdChk("rx status", regA(12), 32'h0000_00FF, {29'h0, RXW[i][10:8]});
      rdChk("rx data", regA(13), 32'h0000_00FF, {24'h0, RXW[i][7:0]});
    end
    xfer(`CABCE_OFS_STATUS, 1'b1, 32'h0000_0200);
    rdChk("overflow clear", `CABCE_OFS_STATUS, 32'h0000_0200, 32'h0000_0000);
  endtask

  // backward then forward call, checking target and stacked state
  task automatic tCall;
    immCase(`CABCE_OP_ADDI, 15, 8'h80, 8'h80, 8'h00, 4'b0111);
    xfer(`CABCE_OFS_PC, 1'b1, 32'h0000_0100);
    xfer(`CABCE_OFS_MODE, 1'b1, 32'h0000_0005);
    exec({8'h9C, 8'h80});
    chk("call target", 32'h0000_0081, q);
    chk("call latency", 32'(waitShort + 1), 32'(execWait));
    rdChk("stack top", `CABCE_OFS_STKTOP, 32'hFFFF_FFFF, {9'h0, 16'h0101, 1'b1, 4'b0111, 2'b10});
    exec({8'h9C, 8'h7F});
    chk("call target", 32'h0000_0101, q);
    rdChk("stack top", `CABCE_OFS_STKTOP, 32'h007F_FF80, {9'h0, 16'h0082, 7'h00});
    rdChk("status after call", `CABCE_OFS_STATUS, 32'h0000_01FF, 32'h0000_0137);
    exec(16'h8000);
    rdChk("illegal opcode", `CABCE_OFS_STATUS, 32'h0000_0400, 32'h0000_0400);
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge coreClk);
    rst <= 1'b0;
    @(posedge coreClk);
    tReset();
    tImm();
    tAcc();
    tIndex();
    tRx();
    tCall();
    completeRun();
  end

  // the run needs a few hundred cycles; this bound only cuts a hang short
  initial begin
    repeat (20000) @(posedge coreClk);
    errTotal++;
    completeRun();
  end
endmodule // cabce_tb
`default_nettype wire
